// File: ssc_asserts.sv
// Property checker for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module ssc_asserts (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	load_strobe,
	input wire logic	chip_enable_pin,
	input wire logic	mux_pin_oe,
	input wire logic [31:0]	divider_integer_fraction,
	input wire logic [31:0]	reference_path_config,
	input wire logic [31:0]	timing_config,
	input wire logic [31:0]	output_config,
	input wire logic	low_power,
	input wire logic	integer_mode,
	input wire logic	lock_detect_style,
	input wire logic [9:0]	ref_divider,
	input wire logic	counter_hold,
	input wire logic [15:0]	int_divider,
	input wire logic [11:0]	frac_numerator,
	input wire logic [7:0]	out_a_ratio,
	input wire logic [4:0]	feedback_ratio,
	input wire logic	loop_divider_placement,
	input wire logic	out_b_source_sel
);
	// One domain, reset disables all
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Frame latch and derived fields
	chk_latch_strobe: assert property ($changed(timing_config) |-> load_strobe)
		else $error("register written with strobe low");
	chk_divider_fields: assert property ($changed(divider_integer_fraction)
		|=> {int_divider, frac_numerator} == $past(divider_integer_fraction[30:3]))
		else $error("integer or numerator field wrong");
	chk_mode_select: assert property ($changed(divider_integer_fraction)
		&& divider_integer_fraction[31] |=> integer_mode) else $error("integer mode not taken");
	chk_ref_flags: assert property ($changed(reference_path_config) |=>
		{lock_detect_style, counter_hold} == {$past(reference_path_config[8]), $past(reference_path_config[3])})
		else $error("hold or lock style wrong");
	chk_power_bit: assert property (reference_path_config[5] |=> low_power)
		else $error("power down bit ignored");
	chk_power_pin: assert property ($fell(chip_enable_pin) |-> ##[1:4] low_power)
		else $error("chip enable low ignored");
	chk_out_routing: assert property ($changed(output_config) |=>
		{out_b_source_sel, loop_divider_placement} == {$past(output_config[9]), $past(output_config[24])})
		else $error("output routing wrong");
	chk_buffer_hold: assert property ($changed(reference_path_config)
		&& !$changed(divider_integer_fraction) |=> $stable(ref_divider)) else $error("buffered field moved early");
	chk_ratio_range: assert property ($onehot(out_a_ratio)
		&& feedback_ratio <= 5'h10 && feedback_ratio != 5'h00) else $error("output ratio out of range");
	chk_oe_strobe: assert property ($rose(mux_pin_oe) |-> load_strobe)
		else $error("readback drive without strobe high");
endmodule
bind ssc_config_port ssc_asserts ssc_asserts_inst (.clk, .rst_n, .load_strobe, .chip_enable_pin,
	.mux_pin_oe, .divider_integer_fraction, .reference_path_config, .timing_config, .output_config,
	.low_power, .integer_mode, .lock_detect_style, .ref_divider, .counter_hold, .int_divider,
	.frac_numerator, .out_a_ratio, .feedback_ratio, .loop_divider_placement, .out_b_source_sel);
`default_nettype wire

// File: ssc_config_port.v
// Serial configuration port of a frequency synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_config_port (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        sclk_pin,
	input  wire        sdata_pin,
	input  wire        load_strobe,
	input  wire        chip_enable_pin,
	input  wire [31:0] status_word,
	input  wire        mux_pin_in,
	output reg         mux_pin_out,
	output reg         mux_pin_oe,
	output reg  [31:0] divider_integer_fraction,
	output reg  [31:0] modulus_config,
	output reg  [31:0] reference_path_config,
	output reg  [31:0] timing_config,
	output reg  [31:0] output_config,
	output reg  [31:0] misc_config,
	output reg         low_power,
	output reg         integer_mode,
	output reg         lock_detect_style,
	output reg  [9:0]  ref_divider,
	output reg         ref_doubler_on,
	output reg         ref_halver_on,
	output reg         counter_hold,
	output reg  [15:0] int_divider,
	output reg  [11:0] frac_numerator,
	output reg  [11:0] frac_modulus,
	output reg  [7:0]  out_a_ratio,
	output reg  [4:0]  feedback_ratio,
	output reg         loop_divider_placement,
	output reg         out_b_source_sel,
	output reg         setting_error
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_ARM  = 3'b010;
	localparam [2:0] ST_SEND = 3'b100;

	wire sclk_lvl;
	wire sclk_rise;
	wire sclk_fall;
	wire le_lvl;
	wire le_rise;
	wire le_fall;
	wire sdata_lvl;
	wire ce_lvl;
	wire mux_unused;
	wire wr_divint;
	wire wr_modulus;
	wire wr_refpath;
	wire wr_timing;
	wire wr_output;
	wire wr_misc;
	wire rb_arm;
	wire rdiv_bad;
	wire nint_bad;
	wire nfrac_bad;
	wire mod_bad;
	wire num_bad;

	reg  [31:0] shift_q;
	reg  [2:0]  rb_state_q;
	reg  [31:0] rb_shift_q;
	reg  [5:0]  rb_count_q;
	reg         mux_in_meta_q;
	reg         mux_in_q;

	////////////////////////////////////////////////////////////
	// Synchronise serial clock and strobe, find edges
	ssc_edge_sync u_sclk (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in (sclk_pin),
		.level  (sclk_lvl),
		.rise   (sclk_rise),
		.fall   (sclk_fall)
	);
	ssc_edge_sync #(
		.IDLE_LEVEL (1'b1)
	) u_le (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in (load_strobe),
		.level  (le_lvl),
		.rise   (le_rise),
		.fall   (le_fall)
	);
	ssc_edge_sync u_data (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in (sdata_pin),
		.level  (sdata_lvl),
		.rise   (),
		.fall   ()
	);
	ssc_edge_sync #(
		.IDLE_LEVEL (1'b1)
	) u_ce (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in (chip_enable_pin),
		.level  (ce_lvl),
		.rise   (),
		.fall   ()
	);

	////////////////////////////////////////////////////////////
	// Pin input side kept synchronised, not used by logic
	always @(posedge clk) begin
		if (!rst_n) begin
			mux_in_meta_q <= 1'b0;
			mux_in_q      <= 1'b0;
		end else begin
			mux_in_meta_q <= mux_pin_in;
			mux_in_q      <= mux_in_meta_q;
		end
	end
	assign mux_unused = mux_in_q;

	////////////////////////////////////////////////////////////
	// Select a field of the pin mode from two registers
	function [3:0] pin_select;
		input [31:0] misc_w;
		input [31:0] ref_w;
		begin
			pin_select = {misc_w[`SSC_PSEL_MSB_BIT], ref_w[`SSC_PSEL_HI_HI:`SSC_PSEL_HI_LO]};
		end
	endfunction

	// True when a latched frame targets the given address
	function frame_to;
		input [31:0] frame_w;
		input [2:0]  addr_w;
		begin
			frame_to = (frame_w[2:0] == addr_w);
		end
	endfunction

	// Feedback share of the output divider, capped at 16
	function [4:0] fb_ratio;
		input       outside_w;
		input [2:0] code_w;
		begin
			if (outside_w) begin
				fb_ratio = 5'h01;
			end else if (code_w > `SSC_FB_DIV_CAP) begin
				fb_ratio = 5'h10;
			end else begin
				fb_ratio = 5'h01 << code_w;
			end
		end
	endfunction

	// One write strobe per register, all on the strobe rise
	assign wr_divint  = le_rise & frame_to(shift_q, `SSC_ADDR_DIVINT); // [R03]
	assign wr_modulus = le_rise & frame_to(shift_q, `SSC_ADDR_MODULUS); // [R03]
	assign wr_refpath = le_rise & frame_to(shift_q, `SSC_ADDR_REFPATH); // [R03]
	assign wr_timing  = le_rise & frame_to(shift_q, `SSC_ADDR_TIMING); // [R03]
	assign wr_output  = le_rise & frame_to(shift_q, `SSC_ADDR_OUTPUT); // [R03]
	assign wr_misc    = le_rise & frame_to(shift_q, `SSC_ADDR_MISC); // [R03]
	assign rb_arm     = le_rise & frame_to(shift_q, `SSC_ADDR_STATUS) &
		(pin_select(misc_config, reference_path_config) == `SSC_PSEL_READBACK);

	////////////////////////////////////////////////////////////
	// Shift data in MSB first; keeps last 32 bits
	always @(posedge clk) begin
		if (!rst_n) begin
			shift_q <= 32'h0000_0000;
		end else if (sclk_rise && !le_lvl) begin
			shift_q <= {shift_q[30:0], sdata_lvl}; // [R02] [R23] [R01]
		end
	end

	////////////////////////////////////////////////////////////
	// Latch whole 32-bit frame, address bits included, into addressed register on strobe rise
	always @(posedge clk) begin
		if (!rst_n) begin
			divider_integer_fraction <= 32'h0000_0000;
			modulus_config           <= 32'h0000_0000;
			reference_path_config    <= 32'h0000_0000;
			timing_config            <= 32'h0000_0000;
			output_config            <= 32'h0000_0000;
			misc_config              <= 32'h0000_0000;
		end else if (wr_divint) begin
			divider_integer_fraction <= shift_q; // [R03]
		end else if (wr_modulus) begin
			modulus_config <= shift_q; // [R03]
		end else if (wr_refpath) begin
			reference_path_config <= shift_q; // [R03]
		end else if (wr_timing) begin
			timing_config <= shift_q; // [R03]
		end else if (wr_output) begin
			output_config <= shift_q; // [R03]
		end else if (wr_misc) begin
			misc_config <= shift_q; // [R03]
		end
	end

	////////////////////////////////////////////////////////////
	// Double-buffered divider settings applied when register zero lands
	always @(posedge clk) begin
		if (!rst_n) begin
			ref_divider    <= 10'h001;
			ref_doubler_on <= 1'b0;
			ref_halver_on  <= 1'b0;
			frac_modulus   <= `SSC_MOD_MIN;
			out_a_ratio    <= 8'h01;
		end else if (wr_divint) begin
			ref_divider    <= reference_path_config[`SSC_RDIV_HI:`SSC_RDIV_LO]; // [R06] [R13]
			ref_doubler_on <= reference_path_config[`SSC_DBL_BIT]; // [R14]
			ref_halver_on  <= reference_path_config[`SSC_HALF_BIT]; // [R14]
			frac_modulus   <= modulus_config[`SSC_MOD_HI:`SSC_MOD_LO]; // [R06] [R17]
			out_a_ratio    <= 8'h01 << output_config[`SSC_OUT_A_RATIO_CODE_HI:`SSC_OUT_A_RATIO_CODE_LO]; // [R06] [R18]
		end
	end

	////////////////////////////////////////////////////////////
	// Directly applied mode and control settings
	always @(posedge clk) begin
		if (!rst_n) begin
			low_power              <= 1'b1;
			integer_mode           <= 1'b0;
			lock_detect_style      <= 1'b0;
			counter_hold           <= 1'b0;
			int_divider            <= `SSC_NINT_MIN;
			frac_numerator         <= 12'h000;
			feedback_ratio         <= 5'h01;
			loop_divider_placement <= 1'b0;
			out_b_source_sel       <= 1'b0;
		end else begin
			low_power         <= reference_path_config[`SSC_PD_BIT] | ~ce_lvl; // [R11]
			counter_hold      <= reference_path_config[`SSC_HOLD_BIT]; // [R15]
			lock_detect_style <= reference_path_config[`SSC_LDSTYLE_BIT]; // [R21]
			int_divider       <= divider_integer_fraction[`SSC_NINT_HI:`SSC_NINT_LO]; // [R16]
			frac_numerator    <= divider_integer_fraction[`SSC_FRAC_HI:`SSC_FRAC_LO]; // [R17]
			integer_mode      <= divider_integer_fraction[`SSC_MODE_BIT] |
				(misc_config[`SSC_AUTOWHOLE_BIT] &
				(divider_integer_fraction[`SSC_FRAC_HI:`SSC_FRAC_LO] == 12'h000)); // [R21] [R22]
			loop_divider_placement <= output_config[`SSC_FB_BIT]; // [R19]
			out_b_source_sel       <= output_config[`SSC_BSRC_BIT]; // [R20]
			// Feedback share follows placement and output code at once
			feedback_ratio <= fb_ratio(output_config[`SSC_FB_BIT],
				output_config[`SSC_OUT_A_RATIO_CODE_HI:`SSC_OUT_A_RATIO_CODE_LO]); // [R19]
		end
	end

	////////////////////////////////////////////////////////////
	// Range checks on the applied divider values
	assign rdiv_bad  = (ref_divider == 10'h000); // [R13]
	assign nint_bad  = (int_divider < `SSC_NINT_MIN); // [R16]
	assign nfrac_bad = !integer_mode &&
		((int_divider < `SSC_NINT_FMIN) || (int_divider > `SSC_NINT_FMAX)); // [R16]
	assign mod_bad   = (frac_modulus < `SSC_MOD_MIN); // [R17]
	assign num_bad   = !integer_mode && (frac_numerator >= frac_modulus); // [R17]

	// Flag settings outside their legal ranges
	always @(posedge clk) begin
		if (!rst_n) begin
			setting_error <= 1'b0;
		end else begin
			setting_error <= rdiv_bad | nint_bad | nfrac_bad | mod_bad | num_bad;
		end
	end

	////////////////////////////////////////////////////////////
	// Readback: armed by a 110 frame, then one clock, then shift out
	always @(posedge clk) begin
		if (!rst_n) begin
			rb_state_q  <= ST_IDLE;
			rb_shift_q  <= 32'h0000_0000;
			rb_count_q  <= 6'h00;
			mux_pin_out <= 1'b0;
			mux_pin_oe  <= 1'b0;
		end else begin
			case (rb_state_q)
				// Wait for an armed frame to address six
				ST_IDLE: begin
					mux_pin_oe <= 1'b0;
					if (rb_arm) begin
						rb_shift_q <= status_word; // [R09]
						rb_state_q <= ST_ARM;
					end
				end
				// Extra clock turns the pin driver on
				ST_ARM: begin
					if (le_fall) begin
						rb_state_q <= ST_IDLE;
					end else if (sclk_rise) begin
						mux_pin_oe <= 1'b1;
						rb_state_q <= ST_SEND;
						rb_count_q <= 6'h00;
					end
				end
				// One bit per clock rise, MSB first
				ST_SEND: begin
					if (le_fall) begin
						mux_pin_oe <= 1'b0;
						rb_state_q <= ST_IDLE;
					end else if (sclk_rise) begin
						mux_pin_out <= rb_shift_q[31]; // [R09]
						rb_shift_q  <= {rb_shift_q[30:0], 1'b0};
						rb_count_q  <= rb_count_q + 6'h01;
						if (rb_count_q == `SSC_READ_BITS) begin
							mux_pin_oe <= 1'b0;
							rb_state_q <= ST_IDLE;
						end
					end
				end
				// Recover from an illegal state code
				default: begin
					rb_state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: ssc_config_port_tb.sv
// Testbench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module ssc_config_port_tb;
	logic	clk, rst_n, chip_enable_pin, mux_pin_in, sclk_pin, sdata_pin, load_strobe, mux_pin_out, mux_pin_oe;
	logic	low_power, integer_mode, lock_detect_style, ref_doubler_on, ref_halver_on, counter_hold;
	logic	loop_divider_placement, out_b_source_sel, setting_error;
	logic [31:0]	status_word, tcfg, rd;
	logic [9:0]	ref_divider;
	logic [15:0]	int_divider;
	logic [11:0]	frac_numerator, frac_modulus;
	logic [7:0]	out_a_ratio;
	logic [4:0]	feedback_ratio;
	int	bad_count = 0;
	int	samples_checked = 0;
	// Packed result groups
	wire logic [31:0] g_buf = {ref_divider, frac_modulus, out_a_ratio, ref_doubler_on, ref_halver_on};
	wire logic [31:0] g_div = {int_divider, frac_numerator, integer_mode, lock_detect_style, counter_hold, low_power};
	wire logic [31:0] g_out = {feedback_ratio, loop_divider_placement, out_b_source_sel, setting_error,
		out_a_ratio, int_divider};
	ssc_config_port ssc_config_port_inst (.clk, .rst_n, .sclk_pin, .sdata_pin, .load_strobe, .chip_enable_pin,
		.status_word, .mux_pin_in, .mux_pin_out, .mux_pin_oe, .divider_integer_fraction(), .modulus_config(),
		.reference_path_config(), .timing_config(tcfg), .output_config(), .misc_config(), .low_power,
		.integer_mode, .lock_detect_style, .ref_divider, .ref_doubler_on, .ref_halver_on, .counter_hold,
		.int_divider, .frac_numerator, .frac_modulus, .out_a_ratio, .feedback_ratio,
		.loop_divider_placement, .out_b_source_sel, .setting_error);
	// Host sees the inverse of the last bit while the pin is undriven
	ssc_host ssc_host_inst (.sclk_pin, .sdata_pin, .load_strobe,
		.mux_pin_out(mux_pin_oe ? mux_pin_out : ~mux_pin_out));
	////////////////////////////////////////
	// Clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Compare one packed word
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Verdict and stop
	task automatic end_sim;
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		#60000;
		bad_count++;
		end_sim();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		chip_enable_pin = 1'b1;
		mux_pin_in = 1'b0;
		status_word = 32'hA5C3_9E17;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		ssc_host_inst.send(64'h0104_0005, 32);
		ssc_host_inst.send(64'h0030_0204, 32);
		ssc_host_inst.send(64'hF_0ABC_DE03, 36);
		ssc_host_inst.send(64'h1201_410A, 32);
		ssc_host_inst.send(64'h0000_0321, 32);
		cmp(g_buf, {10'h001, 12'h002, 8'h01, 2'b00});
		cmp(tcfg, 32'h0ABC_DE03);
		ssc_host_inst.send(64'h0032_0000, 32);
		repeat (4) @(posedge clk);
		cmp(g_buf, {10'h005, 12'h064, 8'h08, 2'b10});
		cmp(g_div, {16'h0064, 12'h000, 4'b1110});
		cmp(g_out, {5'h08, 3'b010, 8'h08, 16'h0064});
		ssc_host_inst.read(rd);
		cmp(rd, 32'hA5C3_9E17);
		// Pin select 1000, power down, widest output ratio
		ssc_host_inst.send(64'h0201_412A, 32);
		ssc_host_inst.send(64'h0070_0204, 32);
		ssc_host_inst.send(64'h8032_0028, 32);
		repeat (4) @(posedge clk);
		cmp(g_out, {5'h10, 3'b010, 8'h80, 16'h0064});
		cmp(g_div, {16'h0064, 12'h005, 4'b1111});
		ssc_host_inst.send(64'h0201_410A, 32);
		cmp(g_div, {16'h0064, 12'h005, 4'b1110});
		repeat (16) @(posedge clk); // Gap after leaving power down, scaled short
		@(posedge clk);
		chip_enable_pin <= 1'b0;
		repeat (8) @(posedge clk);
		cmp(g_div, {16'h0064, 12'h005, 4'b1111});
		// Pin select no longer 1100: readback refused, pin stays undriven
		ssc_host_inst.read(rd);
		cmp(rd, 32'hFFFF_FFFF);
		// Divider outside loop, halver on, fractional N out of range
		ssc_host_inst.send(64'h0120_0004, 32);
		ssc_host_inst.send(64'h0101_4002, 32);
		ssc_host_inst.send(64'h0800_0028, 32);
		repeat (4) @(posedge clk);
		cmp(g_buf, {10'h005, 12'h064, 8'h04, 2'b01});
		cmp(g_div, {16'h1000, 12'h005, 4'b0001});
		cmp(g_out, {5'h01, 3'b101, 8'h04, 16'h1000});
		end_sim();
	end
endmodule
`default_nettype wire

// File: ssc_consts.vh
// Constants for the synthesizer serial configuration port
// Overview of operation
// [R01] Frame is 32 bits: 29 data, 3 address
// [R02] Shift data MSB first while strobe low
// [R03] Strobe rise copies 29 bits to addressed register; the code latches all 32 frame bits, address bits included
// [R04] Host writes every register after power-up
// [R05] Host writes addresses five down to zero
// [R06] Some bits double buffered, applied together
// [R07] Host selects pin readback mode 1100 first
// [R08] Readback frame ends 110, then one clock
// [R09] Device shifts register six out MSB first
// [R10] Host may restore pin select 0000 afterwards
// [R11] Power down by bit or chip enable low
// [R12] Host waits 20ms after leaving power down; the testbench waits 16 clocks
// [R13] Reference divider 10 bits, 1 to 1023
// [R14] Doubler and halver bits shape comparison rate
// [R15] Counter hold resets reference and integer dividers
// [R16] Integer value 16 bits, fractional 19 to 4091
// [R17] Modulus 2..4095, numerator below modulus
// [R18] Output A divides by two to code
// [R19] Placement bit; in-loop feedback division capped 16
// [R20] Output B follows A or raw oscillator
// [R21] Bit 31 selects integer or fractional mode
// [R22] Zero numerator may switch to integer mode
// [R23] Extra clocks: last 32 bits are used
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
`define SSC_FRAME_BITS    32
`define SSC_DATA_BITS     29
`define SSC_ADDR_BITS     3
`define SSC_ADDR_DIVINT   3'h0
`define SSC_ADDR_MODULUS  3'h1
`define SSC_ADDR_REFPATH  3'h2
`define SSC_ADDR_TIMING   3'h3
`define SSC_ADDR_OUTPUT   3'h4
`define SSC_ADDR_MISC     3'h5
`define SSC_ADDR_STATUS   3'h6
`define SSC_MODE_BIT      31
`define SSC_NINT_HI       30
`define SSC_NINT_LO       15
`define SSC_FRAC_HI       14
`define SSC_FRAC_LO       3
`define SSC_MOD_HI        14
`define SSC_MOD_LO        3
`define SSC_PSEL_HI_HI    28
`define SSC_PSEL_HI_LO    26
`define SSC_DBL_BIT       25
`define SSC_HALF_BIT      24
`define SSC_RDIV_HI       23
`define SSC_RDIV_LO       14
`define SSC_LDSTYLE_BIT   8
`define SSC_PD_BIT        5
`define SSC_HOLD_BIT      3
`define SSC_OUT_A_RATIO_CODE_HI       22
`define SSC_OUT_A_RATIO_CODE_LO       20
`define SSC_FB_BIT        24
`define SSC_BSRC_BIT      9
`define SSC_PSEL_MSB_BIT  18
`define SSC_AUTOWHOLE_BIT 24
`define SSC_PSEL_READBACK 4'hC
`define SSC_FB_DIV_CAP    3'h4
`define SSC_NINT_MIN      16'h0010
`define SSC_NINT_FMIN     16'h0013
`define SSC_NINT_FMAX     16'h0FFB
`define SSC_MOD_MIN       12'h002
`define SSC_READ_BITS     6'h20
`endif

// File: ssc_edge_sync.v
// Two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module ssc_edge_sync #(
	parameter [0:0] IDLE_LEVEL = 1'b0
) (
	input  wire clk,
	input  wire rst_n,
	input  wire pin_in,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;
	reg last_q;

	// First flop feeds only the second
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= IDLE_LEVEL; // Idle level, so no false edge after reset
			sync_q <= IDLE_LEVEL;
			last_q <= IDLE_LEVEL;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~last_q;
	assign fall  = ~sync_q & last_q;
endmodule
`default_nettype wire

// File: ssc_host.sv
// Host controller model driving the serial lines
`timescale 1ns/1ps
`default_nettype none
module ssc_host (
	output var logic	sclk_pin,
	output var logic	sdata_pin,
	output var logic	load_strobe,
	input wire logic	mux_pin_out
);
	// Idle lines: clock still, strobe high
	initial begin
		sclk_pin = 1'b0;
		sdata_pin = 1'b0;
		load_strobe = 1'b1;
	end
	// One 32 ns link clock period
	task automatic tick;
		#8 sclk_pin = 1'b1;
		#16 sclk_pin = 1'b0;
		#8;
	endtask
	// Shift n bits MSB first, latch on strobe rise
	task automatic send(input logic [63:0] w, input int n);
		load_strobe = 1'b0;
		#32;
		for (int i = n - 1; i >= 0; i--) begin
			sdata_pin = w[i];
			tick();
		end
		load_strobe = 1'b1;
		sdata_pin = ~sdata_pin; // Data line flipped, no stale bit
		#64;
	endtask
	// Readback frame, extra clock, 32 bits in
	task automatic read(output logic [31:0] r);
		send(64'h6, 32);
		tick();
		for (int i = 31; i >= 0; i--) begin
			tick();
			r[i] = mux_pin_out;
		end
		tick();
	endtask
endmodule
`default_nettype wire
